// ### src/tcs_sequencer.sv
/*
 Acquisition sequencer: decodes the setup word, steps memory addresses
 for samples, handles pre/post trigger modes and the record-done flag.
 Assumes a per-sample enable from the selected sampling clock, a
 converter result per channel strobe, and external 12-bit memory.
*/
`timescale 1ns/1ps
`include "tcs_params.svh"
module tcs_sequencer #(
   parameter int ADDR_W = `TCS_ADDR_W,
   parameter int SMP_W  = `TCS_SAMPLE_W,
   parameter int FDEPTH = `TCS_FIFO_DEPTH
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              compat_mode,
   input  wire logic [ADDR_W:0]   mem_size,
   input  wire logic              arm_cmd,
   input  wire logic [23:0]       setup_data,
   input  wire logic              rearm_cmd,
   input  wire logic              set_done_cmd,
   input  wire logic              trigger_cmd,
   input  wire logic              trigger_in,
   input  wire logic              sample_tick,
   input  wire logic [SMP_W-1:0]  adc_data,
   input  wire logic              adc_valid,
   output logic                   scan_start,
   output logic      [4:0]        adc_channel,
   output logic                   adc_ready,
   output logic      [ADDR_W-1:0] mem_addr,
   output logic      [SMP_W-1:0]  mem_data,
   output logic                   mem_we,
   input  wire logic              mem_ready,
   output logic                   record_done_flag,
   output logic                   capture_mode_bit,
   output logic      [3:0]        rate_select,
   output logic      [ADDR_W-1:0] oldest_addr,
   output logic      [ADDR_W:0]   valid_count,
   output logic                   armed
);
   localparam int FW = ADDR_W + SMP_W;

   typedef struct packed {
      tcs_pkg::tcs_state_e state;
      logic [23:0]         setup;
      logic [5:0]          nchan;
      logic [ADDR_W-1:0]   addr;
      logic [ADDR_W:0]     fill;
      logic [ADDR_W+21:0]  post_left;
      logic                triggered;
      logic                trig_s1;
      logic                trig_s2;
      logic                trig_s3;
      logic                pend_first;
      logic [4:0]          chan;
      logic                scanning;
      logic                done;
      logic [ADDR_W-1:0]   oldest;
      logic [ADDR_W:0]     vcount;
      logic                scan_go;
   } tcs_s;
   tcs_s st_reg, st_next;

   logic [FW-1:0] f_in, f_out;
   logic          f_in_ready, f_out_valid;
   logic          trig_edge, host_trig, stopping, push;

   // Channel code decode
   function automatic logic [5:0] chan_count(input logic [2:0] code,
                                             input logic       compat);
      logic [5:0] n;
      n = 6'h00;
      if (compat) begin
         unique case (code)
            3'h0: n = 6'h20;
            3'h1: n = 6'h10;
            3'h2: n = 6'h08;
            3'h3: n = 6'h04;
            default: n = 6'h20;
         endcase
      end else begin
         unique case (code)
            3'h0: n = 6'h20;
            3'h1: n = 6'h10;
            3'h4: n = 6'h02;
            3'h5: n = 6'h01;
            default: n = 6'h20;
         endcase
      end
      return n;
   endfunction

   // Post-trigger word total: blocks x channels x 16
   function automatic logic [ADDR_W+21:0] post_words(input logic [15:0] b,
                                                     input logic [5:0] n);
      return (ADDR_W+22)'(b) * (ADDR_W+22)'(n)
             * (ADDR_W+22)'(`TCS_SAMPLES_PER_BLK);
   endfunction

   tcs_fifo #(
      .WIDTH (FW),
      .DEPTH (FDEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (f_in),
      .in_valid  (push),
      .in_ready  (f_in_ready),
      .out_data  (f_out),
      .out_valid (f_out_valid),
      .out_ready (mem_ready)
   );

   ////////////////////////////////////////////////////////////////////////
   // Memory side straight from the FIFO
   assign mem_we   = f_out_valid;
   assign mem_addr = f_out[FW-1:SMP_W];
   assign mem_data = f_out[SMP_W-1:0];

   // Converter results stall when the FIFO backs up
   assign adc_ready = st_reg.scanning && f_in_ready && !stopping;
   assign push      = adc_valid && adc_ready;
   assign f_in      = {st_reg.addr, adc_data};

   // Only the second and third stages feed edge logic; s1 is synchroniser-only
   assign trig_edge = st_reg.trig_s2 && !st_reg.trig_s3;
   assign host_trig = trig_edge || trigger_cmd;
   assign stopping  = set_done_cmd;

   assign scan_start       = st_reg.scan_go;
   assign adc_channel      = st_reg.chan;
   assign record_done_flag = st_reg.done;
   assign capture_mode_bit = st_reg.setup[`TCS_MODE_BIT];
   assign rate_select      = st_reg.setup[`TCS_RATE_MSB:`TCS_RATE_LSB];
   assign oldest_addr      = st_reg.oldest;
   assign valid_count      = st_reg.vcount;
   assign armed            = (st_reg.state == tcs_pkg::TCS_WAIT) ||
                             (st_reg.state == tcs_pkg::TCS_RUN);

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [ADDR_W:0] nxt;
      logic            last_ch;
      nxt = '0;
      last_ch = 1'b0;
      st_next = st_reg;
      st_next.scan_go = 1'b0;
      st_next.trig_s1 = trigger_in;
      st_next.trig_s2 = st_reg.trig_s1;
      st_next.trig_s3 = st_reg.trig_s2;

      unique case (st_reg.state)
         tcs_pkg::TCS_IDLE, tcs_pkg::TCS_DONE: begin
            // Clocks and triggers ignored here until armed
         end
         tcs_pkg::TCS_WAIT: begin
            if (host_trig) begin
               // Scan begins on the next sample tick
               st_next.state      = tcs_pkg::TCS_RUN;
               st_next.triggered  = 1'b1;
               st_next.pend_first = 1'b1;
            end
         end
         tcs_pkg::TCS_RUN: begin
            if (host_trig && !st_reg.triggered) begin
               st_next.triggered = 1'b1;
               // Rest of a running scan predates the trigger
               st_next.pend_first = 1'b1;
            end
            if (sample_tick && !st_reg.scanning) begin
               st_next.scanning   = 1'b1;
               st_next.chan       = '0;
               st_next.scan_go    = 1'b1;
               st_next.pend_first = 1'b0;
            end
            if (push) begin
               // Sequential words, channel 0 first
               nxt = {1'b0, st_reg.addr} + 1'b1;
               last_ch = ({1'b0, st_reg.chan} + 6'h01) == st_reg.nchan;
               st_next.chan = last_ch ? 5'h00 : st_reg.chan + 5'h01;
               if (last_ch) st_next.scanning = 1'b0;
               if (st_reg.fill != mem_size) st_next.fill = st_reg.fill + 1'b1;
               if (nxt >= mem_size) begin
                  st_next.addr = '0;
                  if (!st_reg.setup[`TCS_MODE_BIT]) begin
                     // Memory full ends post-trigger capture
                     st_next.state    = tcs_pkg::TCS_DONE;
                     st_next.done     = 1'b1;
                     st_next.scanning = 1'b0;
                     st_next.vcount   = st_reg.fill + 1'b1;
                  end
               end else begin
                  st_next.addr = nxt[ADDR_W-1:0];
               end
               if (st_reg.setup[`TCS_MODE_BIT] && st_reg.triggered &&
                   !st_reg.pend_first) begin
                  st_next.post_left = st_reg.post_left - 1'b1;
                  if (st_reg.post_left == {{(ADDR_W+21){1'b0}}, 1'b1}) begin
                     // Blocks complete: stop and save pointers
                     st_next.state    = tcs_pkg::TCS_DONE;
                     st_next.done     = 1'b1;
                     st_next.scanning = 1'b0;
                     st_next.oldest   = (st_reg.fill == mem_size ||
                                         nxt >= mem_size) ?
                                        st_next.addr : '0;
                     st_next.vcount   = (st_reg.fill != mem_size) ?
                                        st_reg.fill + 1'b1 : st_reg.fill;
                  end
               end
            end
            // Zero blocks: stop at the first scan boundary
            if (st_reg.setup[`TCS_MODE_BIT] && st_reg.triggered &&
                !st_reg.scanning && st_reg.post_left == '0) begin
               st_next.state    = tcs_pkg::TCS_DONE;
               st_next.done     = 1'b1;
               st_next.scanning = 1'b0;
               st_next.scan_go  = 1'b0;
               st_next.vcount   = st_reg.fill;
               st_next.oldest   = (st_reg.fill == mem_size) ? st_reg.addr : '0;
            end
         end
         default: st_next.state = tcs_pkg::TCS_IDLE;
      endcase

      // Only a live acquisition stops; latched results stand
      if (stopping && (st_reg.state == tcs_pkg::TCS_WAIT ||
                       st_reg.state == tcs_pkg::TCS_RUN)) begin
         st_next.state    = tcs_pkg::TCS_DONE;
         st_next.scan_go  = 1'b0;
         st_next.done     = 1'b1;
         st_next.scanning = 1'b0;
         st_next.vcount   = st_reg.fill;
         st_next.oldest   = (st_reg.fill == mem_size) ? st_reg.addr : '0;
      end

      if (arm_cmd || rearm_cmd) begin
         // Latch settings, clear flag, zero pointer
         if (arm_cmd) st_next.setup = setup_data;
         st_next.nchan = chan_count(
            arm_cmd ? setup_data[`TCS_CHAN_MSB:`TCS_CHAN_LSB]
                    : st_reg.setup[`TCS_CHAN_MSB:`TCS_CHAN_LSB], compat_mode);
         st_next.post_left = post_words(
            arm_cmd ? setup_data[`TCS_BLK_MSB:`TCS_BLK_LSB]
                    : st_reg.setup[`TCS_BLK_MSB:`TCS_BLK_LSB],
            st_next.nchan);
         st_next.done      = 1'b0;
         st_next.addr      = '0;
         st_next.fill      = '0;
         st_next.chan      = '0;
         st_next.scanning  = 1'b0;
         st_next.triggered = 1'b0;
         // No stray scan start from a tick in the arming cycle
         st_next.scan_go    = 1'b0;
         st_next.pend_first = 1'b0;
         // Mode bit selects immediate run or trigger wait
         if (arm_cmd ? setup_data[`TCS_MODE_BIT]
                     : st_reg.setup[`TCS_MODE_BIT])
            st_next.state = tcs_pkg::TCS_RUN;
         else
            st_next.state = tcs_pkg::TCS_WAIT;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg        <= '0;
         st_reg.state  <= tcs_pkg::TCS_IDLE;
         st_reg.setup  <= `TCS_SETUP_RESET;
         st_reg.nchan  <= 6'h20;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// ### include/tcs_params.svh
/*
 Constants for the transient capture sequencer: setup word fields,
 block length, memory size defaults. Assumes inclusion by bare name.
*/
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

`define TCS_MODE_BIT        0
`define TCS_RATE_LSB        1
`define TCS_RATE_MSB        4
`define TCS_CHAN_LSB        5
`define TCS_CHAN_MSB        7
`define TCS_BLK_LSB         8
`define TCS_BLK_MSB         23
`define TCS_SETUP_RESET     24'h000000
`define TCS_ADDR_W          20
`define TCS_SAMPLES_PER_BLK 16
`define TCS_FIFO_DEPTH      8
`define TCS_SAMPLE_W        12

`endif

// ### include/tcs_pkg.sv
/*
 Types for the transient capture sequencer.
 Assumes tcs_params.svh is available on the include path.
*/
package tcs_pkg;
   typedef enum logic [3:0] {
      TCS_IDLE = 4'b0001,
      TCS_WAIT = 4'b0010,
      TCS_RUN  = 4'b0100,
      TCS_DONE = 4'b1000
   } tcs_state_e;
endpackage

// ### src/tcs_fifo.sv
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module tcs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } tcs_fifo_s;
   tcs_fifo_s st_reg, st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign in_ready  = (st_reg.cnt != DEPTH[AW:0]);
   assign out_valid = (st_reg.cnt != '0);
   assign out_data  = mem[st_reg.rp];
   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;

   always_comb begin
      st_next = st_reg;
      if (push) st_next.wp = st_reg.wp + 1'b1;
      if (pop) st_next.rp = st_reg.rp + 1'b1;
      st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk) begin
      if (!rst_n) st_reg <= '0;
      else st_reg <= st_next;
      if (push) mem[st_reg.wp] <= in_data;
   end
endmodule

// ### sim/tcs_sequencer_properties.sv
/*
 Port assertions for the capture sequencer.
 Assumes one clock, sync active-low reset; bound below to every instance.
*/
`timescale 1ns/1ps
module tcs_sequencer_properties #(
   parameter int ADDR_W = 20
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W:0]   mem_size,
   input wire logic              arm_cmd,
   input wire logic              rearm_cmd,
   input wire logic [23:0]       setup_data,
   input wire logic              set_done_cmd,
   input wire logic              scan_start,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_we,
   input wire logic              mem_ready,
   input wire logic              record_done_flag,
   input wire logic              capture_mode_bit,
   input wire logic [3:0]        rate_select,
   input wire logic              armed
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   property p_arm_clear; arm_cmd |=> !record_done_flag && armed; endproperty
   a_arm_clear: assert property (p_arm_clear)
      else $error("arm left done set");
   property p_mode; arm_cmd |=> capture_mode_bit == $past(setup_data[0]);
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode bit not latched");
   property p_rate; arm_cmd |=> rate_select == $past(setup_data[4:1]);
   endproperty
   a_rate: assert property (p_rate)
      else $error("rate field misplaced");
   property p_stop;
      set_done_cmd && armed && !arm_cmd && !rearm_cmd |=> record_done_flag;
   endproperty
   a_stop: assert property (p_stop)
      else $error("set done ignored");
   property p_hold;
      record_done_flag && !arm_cmd && !rearm_cmd |=> record_done_flag;
   endproperty
   a_hold: assert property (p_hold)
      else $error("done flag dropped");
   property p_quiet; record_done_flag && $past(record_done_flag) |-> !scan_start;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("scan after done");
   property p_size; mem_we |-> {1'b0, mem_addr} < mem_size; endproperty
   a_size: assert property (p_size)
      else $error("address beyond memory size");
   property p_post_idle; arm_cmd && !setup_data[0] |=> !scan_start [*2];
   endproperty
   a_post_idle: assert property (p_post_idle)
      else $error("post mode scanned before trigger");
   // Guarded on arm, in case arming flushes the buffer
   property p_fifo;
      mem_we && !mem_ready && !arm_cmd && !rearm_cmd |=>
         mem_we && $stable(mem_addr);
   endproperty
   a_fifo: assert property (p_fifo)
      else $error("stalled word changed");
endmodule
bind tcs_sequencer tcs_sequencer_properties #(.ADDR_W(ADDR_W)) u_props (
   .clk, .rst_n, .mem_size, .arm_cmd, .rearm_cmd, .setup_data, .set_done_cmd,
   .scan_start, .mem_addr, .mem_we, .mem_ready, .record_done_flag,
   .capture_mode_bit, .rate_select, .armed);

// ### sim/tcs_far_model.sv
/*
 Converter and 64-word sample memory model for the sequencer.
 Assumes the bench raises slow to stall both sides.
*/
`timescale 1ns/1ps
module tcs_far_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic        arm_cmd,
   input  wire logic [4:0]  adc_channel,
   input  wire logic        adc_ready,
   output logic      [11:0] adc_data,
   output logic             adc_valid,
   input  wire logic [19:0] mem_addr,
   input  wire logic [11:0] mem_data,
   input  wire logic        mem_we,
   output logic             mem_ready
);
   logic [11:0] words [64];
   int          nwr;
   logic        wrapped;
   logic [1:0]  cyc;
   assign adc_valid = !(slow && cyc[0]);
   // Result carries its channel; junk while not valid
   assign adc_data  = adc_valid ? {7'h00, adc_channel} : {7'h7f, ~adc_channel};
   assign mem_ready = !(slow && cyc == 2'h0);
   always_ff @(posedge clk) begin
      cyc <= rst_n ? cyc + 2'h1 : 2'h0;
      if (!rst_n || arm_cmd) begin
         nwr <= 0;
         wrapped <= 1'b0;
      end else if (mem_we && mem_ready) begin
         words[mem_addr[5:0]] <= mem_data;
         nwr <= nwr + 1;
         if (mem_addr == 20'h00000 && nwr != 0) wrapped <= 1'b1;
      end
   end
endmodule

// ### sim/transient_capture_sequencer_tb_top.sv
/*
 Self-checking bench for the capture sequencer.
 Assumes the far model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module transient_capture_sequencer_tb_top;
   localparam int MSZ = 64;
   logic        clk, rst_n, compat_mode, arm_cmd, rearm_cmd, set_done_cmd;
   logic        trigger_cmd, trigger_in, sample_tick, tick_en, slow;
   logic        adc_valid, adc_ready, mem_ready, mem_we, scan_start;
   logic        record_done_flag, capture_mode_bit, armed;
   logic [23:0] setup_data;
   logic [11:0] adc_data, mem_data;
   logic [19:0] mem_addr, oldest_addr;
   logic [20:0] valid_count;
   logic [4:0]  adc_channel;
   logic [3:0]  rate_select;
   int          failures, samples_checked, tcnt, base;
   tcs_sequencer dut (.clk, .rst_n, .compat_mode, .mem_size(21'h000040),
      .arm_cmd, .setup_data, .rearm_cmd, .set_done_cmd, .trigger_cmd,
      .trigger_in, .sample_tick, .adc_data, .adc_valid, .scan_start,
      .adc_channel, .adc_ready, .mem_addr, .mem_data, .mem_we, .mem_ready,
      .record_done_flag, .capture_mode_bit, .rate_select, .oldest_addr,
      .valid_count, .armed);
   tcs_far_model far (.clk, .rst_n, .slow, .arm_cmd(arm_cmd | rearm_cmd),
      .adc_channel, .adc_ready, .adc_data, .adc_valid, .mem_addr, .mem_data,
      .mem_we, .mem_ready);
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(negedge clk) begin
      tcnt <= (tcnt == 47) ? 0 : tcnt + 1;
      sample_tick <= tick_en && tcnt == 0;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic arm(input logic [23:0] w);
      setup_data = w;
      pulse(arm_cmd);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_done(input int lim);
      while (record_done_flag !== 1'b1 && lim > 0) begin
         lim--;
         @(negedge clk);
      end
      chk(record_done_flag, 1'b1);
   endtask
   task automatic chk_order(input int nch);
      for (int i = 0; i < MSZ; i++) chk(far.words[i], i % nch);
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Longest test runs about 3500 cycles
   initial begin
      #(4 * 40000);
      failures++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, compat_mode, arm_cmd, rearm_cmd, set_done_cmd} = '0;
      {trigger_cmd, trigger_in, sample_tick, tick_en, slow} = '0;
      setup_data = '0;
      tcnt = 0;
      failures = 0;
      samples_checked = 0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      tick_en = 1'b1;
      slow = 1'b1;
      arm(24'h0003a2);
      ticks(200);
      chk(far.nwr, 0);
      chk(rate_select, 4'h1);
      pulse(trigger_cmd);
      wait_done(MSZ * 48 + 400);
      ticks(20);
      base = far.nwr;
      chk(base, MSZ);
      chk(valid_count, MSZ);
      chk_order(1);
      pulse(trigger_cmd);
      ticks(200);
      chk(far.nwr, base);
      $display("test post_fill done");
      arm(24'h000185);
      chk(record_done_flag, 1'b0);
      ticks(48 * 40);
      chk(far.wrapped, 1'b1);
      wait (sample_tick);
      ticks(20);
      base = far.nwr;
      pulse(trigger_cmd);
      wait_done(48 * 20);
      ticks(20);
      chk(far.nwr - base, 32);
      chk(oldest_addr, far.nwr % MSZ);
      chk(valid_count, MSZ);
      chk_order(2);
      $display("test pre_ring done");
      compat_mode = 1'b1;
      arm(24'h000066);
      trigger_in = 1'b1;
      ticks(48 * 3);
      trigger_in = 1'b0;
      chk(far.nwr > 0, 1'b1);
      pulse(set_done_cmd);
      chk(record_done_flag, 1'b1);
      ticks(20);
      base = far.nwr;
      ticks(150);
      chk(far.nwr, base);
      chk(valid_count, base);
      pulse(rearm_cmd);
      chk(record_done_flag, 1'b0);
      chk(armed, 1'b1);
      ticks(150);
      chk(far.nwr, 0);
      $display("test stop_rearm done");
      compat_mode = 1'b0;
      arm(24'h0000a3);
      ticks(200);
      wait (sample_tick);
      ticks(20);
      base = far.nwr;
      pulse(trigger_cmd);
      wait_done(100);
      ticks(100);
      chk(far.nwr, base);
      chk(valid_count, base);
      $display("test zero_blocks done");
      close_out();
   end
endmodule
